// [design/rcp_pkg.sv]
// package for the radio configuration and power control block
// assumes 16-bit serial command words, msb first, from the host
package rcp_pkg;
  // ---------------------------------------------------------------
  // command words and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CFG_CMD_HI   = 8'h80;
  localparam logic [7:0]  PWR_CMD_HI   = 8'h82;
  localparam logic [7:0]  STAT_CMD_HI  = 8'h00;
  localparam logic [15:0] CFG_RESET    = 16'h8008;
  localparam logic [15:0] PWR_RESET    = 16'h8208;
  localparam int          CMD_BITS     = 16;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_TXREG_BIT  = 7;
  localparam int CFG_FIFO_BIT   = 6;
  localparam int CFG_BAND_LSB   = 4;
  localparam int PWR_RX_BIT     = 7;
  localparam int PWR_BB_BIT     = 6;
  localparam int PWR_TX_BIT     = 5;
  localparam int PWR_SYN_BIT    = 4;
  localparam int PWR_OSC_BIT    = 3;
  localparam int PWR_BAT_BIT    = 2;
  localparam int PWR_WAKE_BIT   = 1;
  localparam int PWR_CKDIS_BIT  = 0;
  // ---------------------------------------------------------------
  // band codes and load capacitance in tenths of a pF
  // ---------------------------------------------------------------
  localparam logic [1:0] BAND_RSVD = 2'h0;
  localparam logic [1:0] BAND_433  = 2'h1;
  localparam logic [1:0] BAND_868  = 2'h2;
  localparam logic [1:0] BAND_915  = 2'h3;
  localparam logic [7:0] CLOAD_BASE_TENTHS = 8'h55;
  localparam logic [7:0] CLOAD_STEP_TENTHS = 8'h05;
  // ---------------------------------------------------------------
  // clock tail length in output clock pulses
  // ---------------------------------------------------------------
  localparam int          CLK_TAIL_PULSES = 192;
  typedef enum logic [1:0] {RCP_MODE_IDLE, RCP_MODE_RX, RCP_MODE_TX} rcp_mode_t;
endpackage

// [design/rcp_power_ctrl.sv]
// configuration and power control registers with oscillator control
// assumes host serial port on sck_in (link clock), sel_n, sdi; clk is core clock
`timescale 1ns/10ps
module rcp_power_ctrl
  import rcp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       sck_in,
  input  wire logic       sel_n,
  input  wire logic       sdi,
  input  wire logic       irq_active,
  input  wire logic       rx_data_in,
  input  wire logic       rx_clk_in,
  input  wire logic       osc_clk_pulse,
  output logic            tx_data_reg_enable,
  output logic            rx_buffer_mode_enable,
  output logic [1:0]      band_select,
  output logic [3:0]      crystal_load_select,
  output logic [7:0]      crystal_load_tenths_pf,
  output logic            band_valid,
  output logic            data_pin_out,
  output logic            recovered_data_clock_out,
  output logic            osc_on,
  output logic            synth_on,
  output logic            baseband_on,
  output logic            frontend_on,
  output logic            pa_on,
  output logic            tx_start,
  output logic            battery_detector_on,
  output logic            wakeup_timer_on,
  output logic            clk_out_buffer_on,
  output logic            baseband_cal_start,
  output logic            synth_cal_start,
  output rcp_mode_t       radio_mode,
  output logic            status_read_done
);
  // ---------------------------------------------------------------
  // link domain: shift in 16-bit words on rising sck
  // ---------------------------------------------------------------
  logic [CMD_BITS-1:0] shift_r;
  logic [4:0]          bitcnt_r;
  logic [CMD_BITS-1:0] word_r;
  logic                word_tgl_r;
  logic [CMD_BITS-1:0] shift_nxt;

  assign shift_nxt = {shift_r[CMD_BITS-2:0], sdi};

  // sel_n high resets the bit count; frame ends need no further sck edge
  always_ff @(posedge sck_in or posedge sel_n) begin
    if (sel_n) begin
      bitcnt_r <= 5'h0;
    end else if (bitcnt_r != 5'(CMD_BITS)) begin
      bitcnt_r <= bitcnt_r + 5'h1;
    end
  end

  always_ff @(posedge sck_in) begin
    shift_r <= shift_nxt;
    if (!sel_n && bitcnt_r == 5'(CMD_BITS - 1)) begin
      word_r <= shift_nxt;
    end
  end

  // toggle needs a known start or the core never sees a strobe;
  // the host keeps sck idle during reset, so the async clear is safe
  always_ff @(posedge sck_in or posedge sys_rst) begin
    if (sys_rst) begin
      word_tgl_r <= 1'b0;
    end else if (!sel_n && bitcnt_r == 5'(CMD_BITS - 1)) begin
      word_tgl_r <= ~word_tgl_r;
    end
  end

  // ---------------------------------------------------------------
  // crossings into clk
  // ---------------------------------------------------------------
  logic [2:0] tgl_sync_r;
  logic [1:0] irq_sync_r;
  logic [1:0] rxd_sync_r;
  logic [1:0] rxc_sync_r;
  logic [1:0] oscp_sync_r;
  logic       oscp_prev_r;
  logic       word_strobe;
  logic       osc_edge;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tgl_sync_r  <= 3'h0;
      irq_sync_r  <= 2'h0;
      rxd_sync_r  <= 2'h0;
      rxc_sync_r  <= 2'h0;
      oscp_sync_r <= 2'h0;
      oscp_prev_r <= 1'b0;
    end else begin
      tgl_sync_r  <= {tgl_sync_r[1:0], word_tgl_r};
      irq_sync_r  <= {irq_sync_r[0], irq_active};
      rxd_sync_r  <= {rxd_sync_r[0], rx_data_in};
      rxc_sync_r  <= {rxc_sync_r[0], rx_clk_in};
      oscp_sync_r <= {oscp_sync_r[0], osc_clk_pulse};
      oscp_prev_r <= oscp_sync_r[1];
    end
  end

  // word_r is stable for many clk cycles after the toggle settles
  assign word_strobe = tgl_sync_r[2] ^ tgl_sync_r[1];
  assign osc_edge    = oscp_sync_r[1] & ~oscp_prev_r;

  // ---------------------------------------------------------------
  // command registers
  // ---------------------------------------------------------------
  logic [7:0] cfg_r;
  logic [7:0] pwr_r;
  logic       stat_seen_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r <= CFG_RESET[7:0];
      pwr_r <= PWR_RESET[7:0];
    end else if (word_strobe) begin
      if (word_r[15:8] == CFG_CMD_HI) begin
        cfg_r <= word_r[7:0];
      end
      if (word_r[15:8] == PWR_CMD_HI) begin
        pwr_r <= word_r[7:0];
      end
    end
  end

  logic rx_en, bb_en, tx_en, syn_en, osc_en, ck_dis;
  assign rx_en  = pwr_r[PWR_RX_BIT];
  assign bb_en  = pwr_r[PWR_BB_BIT];
  assign tx_en  = pwr_r[PWR_TX_BIT];
  assign syn_en = pwr_r[PWR_SYN_BIT];
  assign osc_en = pwr_r[PWR_OSC_BIT];
  assign ck_dis = pwr_r[PWR_CKDIS_BIT];

  logic status_rd;
  assign status_rd = word_strobe && (word_r[15:8] == STAT_CMD_HI);

  // ---------------------------------------------------------------
  // oscillator hold: interrupts, status read and clock tail
  // ---------------------------------------------------------------
  logic       osc_run_r;
  logic [7:0] tail_cnt_r;
  logic       tail_r;
  logic       osc_req;

  // status read arms the tail; a pending interrupt disarms it again
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_seen_r <= 1'b0;
    end else if (status_rd) begin
      stat_seen_r <= 1'b1;
    end else if (irq_sync_r[1] || osc_req) begin
      stat_seen_r <= stat_seen_r & ~irq_sync_r[1];
    end
  end

  // interrupt hold only while the clock output is enabled (ck_dis low)
  assign osc_req = osc_en | rx_en | tx_en
                 | (~ck_dis & irq_sync_r[1]);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_run_r  <= 1'b1;
      tail_r     <= 1'b0;
      tail_cnt_r <= 8'h0;
    end else if (osc_req) begin
      osc_run_r  <= 1'b1;
      tail_r     <= 1'b0;
      tail_cnt_r <= 8'h0;
    end else if (osc_run_r && !tail_r) begin
      if (!ck_dis && stat_seen_r) begin
        tail_r     <= 1'b1;
        tail_cnt_r <= 8'h0;
      end else begin
        osc_run_r <= 1'b0;
      end
    end else if (tail_r && osc_edge) begin
      if (tail_cnt_r == 8'(CLK_TAIL_PULSES - 1)) begin
        tail_r    <= 1'b0;
        osc_run_r <= 1'b0;
      end else begin
        tail_cnt_r <= tail_cnt_r + 8'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // block power resolution
  // ---------------------------------------------------------------
  logic syn_nxt, bb_nxt, fe_nxt, pa_nxt;
  assign syn_nxt = osc_run_r & (syn_en | rx_en | tx_en);
  assign bb_nxt  = syn_nxt & (bb_en | rx_en);
  assign fe_nxt  = osc_run_r & rx_en;
  assign pa_nxt  = syn_nxt & tx_en & ~rx_en;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_on              <= 1'b1;
      synth_on            <= 1'b0;
      baseband_on         <= 1'b0;
      frontend_on         <= 1'b0;
      pa_on               <= 1'b0;
      tx_start            <= 1'b0;
      battery_detector_on <= 1'b0;
      wakeup_timer_on     <= 1'b0;
      clk_out_buffer_on   <= 1'b1;
      baseband_cal_start  <= 1'b0;
      synth_cal_start     <= 1'b0;
      radio_mode          <= RCP_MODE_IDLE;
      status_read_done    <= 1'b0;
    end else begin
      osc_on              <= osc_run_r;
      synth_on            <= syn_nxt;
      baseband_on         <= bb_nxt;
      frontend_on         <= fe_nxt;
      pa_on               <= pa_nxt;
      tx_start            <= pa_nxt & cfg_r[CFG_TXREG_BIT];
      battery_detector_on <= pwr_r[PWR_BAT_BIT];
      wakeup_timer_on     <= pwr_r[PWR_WAKE_BIT];
      clk_out_buffer_on   <= ~ck_dis & osc_run_r;
      // calibration only when the block powers up from off
      baseband_cal_start  <= bb_nxt & ~baseband_on;
      synth_cal_start     <= syn_nxt & ~synth_on;
      status_read_done    <= status_rd;
      if (fe_nxt) begin
        radio_mode <= RCP_MODE_RX;
      end else if (pa_nxt) begin
        radio_mode <= RCP_MODE_TX;
      end else begin
        radio_mode <= RCP_MODE_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration decode and data pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_data_reg_enable       <= CFG_RESET[CFG_TXREG_BIT];
      rx_buffer_mode_enable    <= CFG_RESET[CFG_FIFO_BIT];
      band_select              <= CFG_RESET[CFG_BAND_LSB +: 2];
      crystal_load_select      <= CFG_RESET[3:0];
      crystal_load_tenths_pf   <= CLOAD_BASE_TENTHS;
      band_valid               <= 1'b0;
      data_pin_out             <= 1'b0;
      recovered_data_clock_out <= 1'b0;
    end else begin
      tx_data_reg_enable     <= cfg_r[CFG_TXREG_BIT];
      rx_buffer_mode_enable  <= cfg_r[CFG_FIFO_BIT];
      band_select            <= cfg_r[CFG_BAND_LSB +: 2];
      crystal_load_select    <= cfg_r[3:0];
      crystal_load_tenths_pf <= CLOAD_BASE_TENTHS
                              + 8'(cfg_r[3:0] * CLOAD_STEP_TENTHS);
      band_valid             <= cfg_r[CFG_BAND_LSB +: 2] != BAND_RSVD;
      // fifo mode holds the pins low; data then goes to the buffer
      data_pin_out             <= ~cfg_r[CFG_FIFO_BIT] & rxd_sync_r[1];
      recovered_data_clock_out <= ~cfg_r[CFG_FIFO_BIT] & rxc_sync_r[1];
    end
  end
endmodule

// [verification/rcp_checker.sv]
// assertions for the radio power control block
// assumes bind into rcp_power_ctrl; only the core clock side is watched
`timescale 1ns/10ps
module rcp_checker
  import rcp_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       irq_active,
  input wire logic [1:0] band_select,
  input wire logic       band_valid,
  input wire logic [3:0] crystal_load_select,
  input wire logic [7:0] crystal_load_tenths_pf,
  input wire logic       rx_buffer_mode_enable,
  input wire logic       data_pin_out,
  input wire logic       osc_on,
  input wire logic       synth_on,
  input wire logic       baseband_on,
  input wire logic       tx_data_reg_enable,
  input wire logic       pa_on,
  input wire logic       tx_start,
  input wire logic       clk_out_buffer_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // inputs pass synchronisers, so levels are judged after a few quiet cycles
  sequence s_irq_held;
    (irq_active && clk_out_buffer_on) [*4];
  endsequence
  a_load_map: assert property ($stable(crystal_load_select) [*3] |->
    crystal_load_tenths_pf == CLOAD_BASE_TENTHS + CLOAD_STEP_TENTHS * crystal_load_select)
    else $error("load map");
  a_band_flag: assert property ($stable(band_select) [*3] |->
    band_valid == (band_select != BAND_RSVD)) else $error("band flag");
  a_syn_osc: assert property (synth_on |-> osc_on)
    else $error("synth without osc");
  a_bb_syn: assert property (baseband_on |-> synth_on)
    else $error("baseband without synth");
  a_tx_gate: assert property (tx_start |-> pa_on && tx_data_reg_enable)
    else $error("tx start gate");
  a_pa_feed: assert property (pa_on |-> osc_on && synth_on)
    else $error("pa without feed");
  a_fifo_pins: assert property (rx_buffer_mode_enable [*3] |-> !data_pin_out)
    else $error("data pin in fifo mode");
  a_irq_osc: assert property (s_irq_held |-> osc_on)
    else $error("irq osc hold");
endmodule
bind rcp_power_ctrl rcp_checker u_chk (.*);

// [verification/rcp_host_model.sv]
// host side serial master for the power control block
// assumes the bench calls send; the link clock only runs inside frames
`timescale 1ns/10ps
module rcp_host_model (
  output logic sck_in,
  output logic sel_n,
  output logic sdi
);
  initial begin
    sck_in = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
  end
  // 15 ns link period; data released to the inverse so a stale bit never passes
  task automatic send(input logic [15:0] w);
    sel_n = 1'b0;
    #10;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      #7.5 sck_in = 1'b1;
      #7.5 sck_in = 1'b0;
    end
    #10 sel_n = 1'b1;
    sdi = ~w[0];
    #100;
  endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the radio power control block
// assumes the host model owns the serial pins; the bench makes osc pulses
`timescale 1ns/10ps
module tb_top;
  import rcp_pkg::*;
  logic       clk = 1'b0, sys_rst = 1'b1, irq_active = 1'b0, osc_run = 1'b1;
  logic       rx_data_in = 1'b0, rx_clk_in = 1'b0, osc_clk_pulse = 1'b0;
  logic       sck_in, sel_n, sdi, tx_data_reg_enable, rx_buffer_mode_enable, band_valid;
  logic       data_pin_out, recovered_data_clock_out, osc_on, synth_on, baseband_on;
  logic       frontend_on, pa_on, tx_start, battery_detector_on, wakeup_timer_on;
  logic       clk_out_buffer_on, baseband_cal_start, synth_cal_start, status_read_done;
  logic [1:0] band_select;
  logic [3:0] crystal_load_select;
  logic [7:0] crystal_load_tenths_pf;
  rcp_mode_t  radio_mode;
  int         bad_count, total_checks, bb_n, syn_n, sr_n, div;
  wire  [8:0] pv = {osc_on, synth_on, baseband_on, frontend_on, pa_on, tx_start,
                    battery_detector_on, wakeup_timer_on, clk_out_buffer_on};
  wire  [7:0] cv = {tx_data_reg_enable, rx_buffer_mode_enable, band_select, crystal_load_select};
  rcp_power_ctrl u_dut (.*);
  rcp_host_model u_host (.sck_in(sck_in), .sel_n(sel_n), .sdi(sdi));
  always #4 clk = ~clk;
  // osc pulses at a tenth of clk, gated so a tail is counted from a clean start
  always @(posedge clk) begin
    div <= (div == 4) ? 0 : div + 1;
    if (div == 4) osc_clk_pulse <= osc_run & ~osc_clk_pulse;
    if (baseband_cal_start === 1'b1) bb_n <= bb_n + 1;
    if (synth_cal_start === 1'b1) syn_n <= syn_n + 1;
    if (status_read_done === 1'b1) sr_n <= sr_n + 1;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // 12 clk covers the link sync and the output stages
  task automatic cmd(input logic [15:0] w);
    u_host.send(w);
    settle(12);
  endtask
  task automatic t_cfg;
    logic [7:0] e, t;
    chk("rst_pwr", 16'(pv), 16'h0101);
    chk("rst_cfg", 16'(cv), 16'h0008);
    for (int b = 0; b < 4; b++) begin
      e = {2'b10, 2'(b), 4'(b * 5)};
      t = CLOAD_BASE_TENTHS + CLOAD_STEP_TENTHS * e[3:0];
      cmd({CFG_CMD_HI, e});
      chk("cfg", 16'(cv), 16'(e));
      chk("tenths", 16'(crystal_load_tenths_pf), 16'(t));
      chk("band_ok", 16'(band_valid), 16'(b != 0));
    end
    @(posedge clk) rx_data_in <= 1'b1;
    rx_clk_in <= 1'b1;
    settle(6);
    chk("pins", 16'({data_pin_out, recovered_data_clock_out}), 16'h0003);
    cmd({CFG_CMD_HI, 8'hC8});
    chk("pins", 16'({data_pin_out, recovered_data_clock_out}), 16'h0000);
    cmd(16'h8400);
    chk("cfg", 16'(cv), 16'h00C8);
    $display("cfg done");
  endtask
  task automatic t_pwr;
    logic [7:0] wd [5] = '{8'h88, 8'h28, 8'h5E, 8'hD8, 8'h09};
    logic [8:0] ep [5] = '{9'h1E1, 9'h199, 9'h1C7, 9'h1E1, 9'h100};
    logic [1:0] em [5] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h0};
    logic [1:0] ec [5] = '{2'h3, 2'h0, 2'h2, 2'h0, 2'h0};
    int b0, s0;
    for (int i = 0; i < 5; i++) begin
      b0 = bb_n;
      s0 = syn_n;
      cmd({PWR_CMD_HI, wd[i]});
      chk("pwr", 16'(pv), 16'(ep[i]));
      chk("mode", 16'(radio_mode), 16'(em[i]));
      chk("cal", 16'((bb_n - b0) * 2 + syn_n - s0), 16'(ec[i]));
    end
    cmd({PWR_CMD_HI, 8'hA8});
    chk("rx_win", 16'({radio_mode, frontend_on}), 16'h0003);
    $display("pwr done");
  endtask
  task automatic t_tail;
    int n;
    logic p;
    cmd({PWR_CMD_HI, 8'h08});
    cmd({PWR_CMD_HI, 8'h00});
    chk("osc_now", 16'(osc_on), 16'h0000);
    @(posedge clk) osc_run <= 1'b0;
    cmd({PWR_CMD_HI, 8'h08});
    n = sr_n;
    cmd(16'h0000);
    chk("stat", 16'(sr_n - n), 16'h0001);
    cmd({PWR_CMD_HI, 8'h00});
    @(posedge clk) osc_run <= 1'b1;
    n = 0;
    for (int i = 0; i < 3000 && osc_on === 1'b1; i++) begin
      p = osc_clk_pulse;
      settle(1);
      if (osc_clk_pulse === 1'b1 && p === 1'b0) n++;
    end
    chk("tail", 16'(n), 16'(CLK_TAIL_PULSES));
    $display("tail done");
  endtask
  task automatic t_irq;
    cmd({PWR_CMD_HI, 8'h08});
    @(posedge clk) irq_active <= 1'b1;
    cmd({PWR_CMD_HI, 8'h00});
    settle(50);
    chk("osc_irq", 16'(osc_on), 16'h0001);
    @(posedge clk) irq_active <= 1'b0;
    settle(12);
    chk("osc_clr", 16'(osc_on), 16'h0000);
    cmd({PWR_CMD_HI, 8'h01});
    @(posedge clk) irq_active <= 1'b1;
    settle(20);
    chk("osc_dc", 16'(osc_on), 16'h0000);
    @(posedge clk) irq_active <= 1'b0;
    $display("irq done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    settle(3);
    t_cfg();
    t_pwr();
    t_tail();
    t_irq();
    give_verdict();
  end
  // the run needs about 26 us; over ten times that means a hang
  initial begin
    #300000;
    bad_count++;
    give_verdict();
  end
endmodule
